// ===== design/ssp_pkg.sv
// constants for the stepper driver spi slave with sleep handling
`default_nettype none

package ssp_pkg;

  // ---------------------------------------------------------------
  // packet format
  // ---------------------------------------------------------------
  localparam int SSP_BYTE_BITS = 8;
  localparam logic [2:0] SSP_CMD_READ = 3'h0;
  localparam logic [2:0] SSP_CMD_WRITE = 3'h4;
  localparam logic [4:0] SSP_WRITE_BITS = 5'h10;
  localparam logic [4:0] SSP_BITS_SAT = 5'h11;
  localparam logic [2:0] SSP_LAST_BIT = 3'h7;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int SSP_NUM_CTRL = 4;
  localparam int SSP_NUM_STAT = 4;
  localparam int SSP_STAT_BITS = 7;
  localparam logic [4:0] SSP_CTRL_BASE = 5'h00;
  localparam logic [4:0] SSP_STAT_BASE = 5'h04;
  localparam logic [4:0] SSP_REG_LIMIT = 5'h08;
  localparam logic [1:0] SSP_MODE_REG = 2'h3;
  localparam int SSP_MOTEN_BIT = 7;
  localparam int SSP_SLEEP_BIT = 6;
  localparam logic [7:0] SSP_CTRL_RESET = 8'h00;
  localparam logic [6:0] SSP_STAT_RESET = 7'h00;
  localparam logic [7:0] SSP_UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] SSP_INVALID_DATA = 8'hFF;
  // status bits that pull the fault pin low (all by default)
  localparam logic [SSP_NUM_STAT*SSP_STAT_BITS-1:0] SSP_FAULT_MASK = 28'hFFFFFFF;

  // ---------------------------------------------------------------
  // receive sequencing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_EXPECT_CMD = 2'b01,
    SSP_EXPECT_DATA = 2'b10
  } ssp_rx_state_t;

endpackage : ssp_pkg

`default_nettype wire

// ===== design/ssp_ctrl_mem.sv
// control register file with registered read port
`default_nettype none
`timescale 1ns/1ps

module ssp_ctrl_mem
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [7:0] mode_reg
);

  logic [7:0] mem_reg [SSP_NUM_CTRL];

  // ---------------------------------------------------------------
  // storage: one word per control register
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SSP_NUM_CTRL; gi++) begin : g_word
      always_ff @(posedge clk) begin
        if (reset) begin
          mem_reg[gi] <= SSP_CTRL_RESET;
        end else if (wr_en && wr_idx == 2'(gi)) begin
          mem_reg[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // read data from a register; address is stable long before use
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= SSP_CTRL_RESET;
    end else begin
      rd_data <= mem_reg[rd_idx];
    end
  end

  // mode register goes straight out to steer sleep and drivers
  assign mode_reg = mem_reg[SSP_MODE_REG];

endmodule : ssp_ctrl_mem

`default_nettype wire

// ===== design/ssp_slave.sv
// spi slave port of the stepper driver with sleep handling
`default_nettype none
`timescale 1ns/1ps

module ssp_slave
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  // spi pins
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // motion inputs from pins
  input wire logic step_pulse_input,
  input wire logic dir_input,
  // status events from analog monitors, four groups of seven
  input wire logic [SSP_NUM_STAT*SSP_STAT_BITS-1:0] status_event,
  // open-drain fault pin, active low
  output logic fault_n_out,
  output logic fault_n_oe,
  // core controls
  output logic step_pulse_out,
  output logic dir_out,
  output logic drivers_enable,
  output logic analog_enable,
  output logic sleep_active,
  output logic core_clock_run
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic [1:0] step_sync_reg;
  logic [1:0] dir_sync_reg;
  // monitor flags are levels from the analog side; each bit syncs on its own
  logic [SSP_NUM_STAT*SSP_STAT_BITS-1:0] event_meta_reg;
  logic [SSP_NUM_STAT*SSP_STAT_BITS-1:0] event_sync_reg;
  logic sclk_prev_reg;
  logic cs_prev_reg;

  // two flops per pin before any logic looks at them
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      sdi_sync_reg <= 2'h0;
      step_sync_reg <= 2'h0;
      dir_sync_reg <= 2'h0;
      event_meta_reg <= '0;
      event_sync_reg <= '0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], spi_clk};
      cs_sync_reg <= {cs_sync_reg[0], spi_cs_n};
      sdi_sync_reg <= {sdi_sync_reg[0], serial_data_in};
      step_sync_reg <= {step_sync_reg[0], step_pulse_input};
      dir_sync_reg <= {dir_sync_reg[0], dir_input};
      event_meta_reg <= status_event;
      event_sync_reg <= event_meta_reg;
    end
  end

  // previous values for edge detection on the second stage only
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_sync_reg[1];
      cs_prev_reg <= cs_sync_reg[1];
    end
  end

  // ---------------------------------------------------------------
  // edge decode
  // ---------------------------------------------------------------
  wire cs_high = cs_sync_reg[1];
  wire selected = ~cs_sync_reg[1];
  wire sclk_rise = selected & sclk_sync_reg[1] & ~sclk_prev_reg;
  wire sclk_fall = selected & ~sclk_sync_reg[1] & sclk_prev_reg;
  wire cs_rise = cs_sync_reg[1] & ~cs_prev_reg;
  wire cs_fall = ~cs_sync_reg[1] & cs_prev_reg;

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [4:0] total_bits_reg;
  logic [4:0] total_bits_next;
  logic [6:0] rx_shift_reg;
  logic byte_done_reg;
  logic [4:0] addr_reg;
  logic addr_valid_reg;
  ssp_rx_state_t rx_state_reg;
  ssp_rx_state_t rx_state_next;
  logic wr_pending_reg;
  logic [4:0] wr_addr_reg;
  logic [7:0] wr_data_reg;

  wire [7:0] rx_byte = {rx_shift_reg, sdi_sync_reg[1]};
  wire last_bit = sclk_rise && bit_cnt_reg == SSP_LAST_BIT;
  wire [2:0] rx_cmd = rx_byte[7:5];
  wire [4:0] rx_addr = rx_byte[4:0];
  wire cmd_is_read = rx_cmd == SSP_CMD_READ;
  wire cmd_is_write = rx_cmd == SSP_CMD_WRITE;
  wire cmd_known = cmd_is_read | cmd_is_write;
  wire take_cmd = last_bit && rx_state_reg == SSP_EXPECT_CMD;
  wire take_data = last_bit && rx_state_reg == SSP_EXPECT_DATA;

  // bit counter restarts on deselect so bytes stay aligned
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    if (cs_high) begin
      bit_cnt_next = 3'h0;
    end else if (sclk_rise) begin
      bit_cnt_next = bit_cnt_reg + 3'h1;
    end
  end

  // packet length, saturating just past sixteen
  always_comb begin
    total_bits_next = total_bits_reg;
    if (cs_fall) begin
      total_bits_next = 5'h00;
    end else if (sclk_rise && total_bits_reg != SSP_BITS_SAT) begin
      total_bits_next = total_bits_reg + 5'h01;
    end
  end

  // a write command is followed by one data byte; reads chain commands
  always_comb begin
    rx_state_next = rx_state_reg;
    if (cs_high) begin
      rx_state_next = SSP_EXPECT_CMD;
    end else if (take_cmd && cmd_is_write) begin
      rx_state_next = SSP_EXPECT_DATA;
    end else if (take_data) begin
      rx_state_next = SSP_EXPECT_CMD;
    end
  end

  // bit and packet counters, shift register, state
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_reg <= 3'h0;
      total_bits_reg <= 5'h00;
      rx_shift_reg <= 7'h00;
      rx_state_reg <= SSP_EXPECT_CMD;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      total_bits_reg <= total_bits_next;
      rx_state_reg <= rx_state_next;
      if (sclk_rise) begin
        rx_shift_reg <= rx_byte[6:0];
      end
    end
  end

  // last read or write index; invalid until the first read or write command byte
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg <= 5'h00;
      addr_valid_reg <= 1'b0;
    end else if (take_cmd && cmd_known) begin
      addr_reg <= rx_addr;
      addr_valid_reg <= 1'b1;
    end
  end

  // byte completion marks the next falling edge as the load point
  always_ff @(posedge clk) begin
    if (reset) begin
      byte_done_reg <= 1'b0;
    end else if (cs_high) begin
      byte_done_reg <= 1'b0;
    end else if (last_bit) begin
      byte_done_reg <= 1'b1;
    end else if (sclk_fall) begin
      byte_done_reg <= 1'b0;
    end
  end

  // captured write, held until chip select rises
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= 8'h00;
    end else if (cs_fall || cs_rise) begin
      wr_pending_reg <= 1'b0;
    end else if (take_cmd && cmd_is_write) begin
      wr_addr_reg <= rx_addr;
      wr_pending_reg <= 1'b0;
    end else if (take_data) begin
      wr_data_reg <= rx_byte;
      wr_pending_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // write commit
  // ---------------------------------------------------------------
  // only exact sixteen-bit packets to a control index are stored
  wire wr_to_ctrl = wr_addr_reg < SSP_STAT_BASE;
  wire wr_len_ok = total_bits_reg == SSP_WRITE_BITS;
  wire commit = cs_rise & wr_pending_reg & wr_len_ok & wr_to_ctrl;

  logic [7:0] ctrl_rd_data;
  logic [7:0] mode_word;

  ssp_ctrl_mem u_ctrl_mem (
    .clk(clk),
    .reset(reset),
    .wr_en(commit),
    .wr_idx(wr_addr_reg[1:0]),
    .wr_data(wr_data_reg),
    .rd_idx(addr_reg[1:0]),
    .rd_data(ctrl_rd_data),
    .mode_reg(mode_word)
  );

  // ---------------------------------------------------------------
  // status registers
  // ---------------------------------------------------------------
  logic [SSP_STAT_BITS-1:0] stat_reg [SSP_NUM_STAT];
  logic [SSP_NUM_STAT-1:0] clr_pending_reg;
  logic [SSP_NUM_STAT*SSP_STAT_BITS-1:0] stat_flat;

  wire addr_is_ctrl = addr_reg < SSP_STAT_BASE;
  wire addr_is_stat = !addr_is_ctrl && addr_reg < SSP_REG_LIMIT;
  wire [1:0] stat_idx = 2'(addr_reg - SSP_STAT_BASE);
  wire [SSP_STAT_BITS-1:0] stat_sel = stat_reg[stat_idx];
  wire stat_parity = ^stat_sel;
  wire load_tx = sclk_fall & byte_done_reg;

  // sticky flags; events win over a pending read clear
  genvar si;
  generate
    for (si = 0; si < SSP_NUM_STAT; si++) begin : g_stat
      wire [SSP_STAT_BITS-1:0] ev = event_sync_reg[si*SSP_STAT_BITS +: SSP_STAT_BITS];
      wire read_now = load_tx && addr_valid_reg && addr_is_stat && stat_idx == 2'(si);

      always_ff @(posedge clk) begin
        if (reset) begin
          stat_reg[si] <= SSP_STAT_RESET;
        end else if (cs_high) begin
          stat_reg[si] <= (clr_pending_reg[si] ? SSP_STAT_RESET : stat_reg[si]) | ev;
        end
      end

      // clear is remembered until chip select goes high
      always_ff @(posedge clk) begin
        if (reset) begin
          clr_pending_reg[si] <= 1'b0;
        end else if (read_now) begin
          clr_pending_reg[si] <= 1'b1;
        end else if (cs_high) begin
          clr_pending_reg[si] <= 1'b0;
        end
      end

      assign stat_flat[si*SSP_STAT_BITS +: SSP_STAT_BITS] = stat_reg[si];
    end
  endgenerate

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic [7:0] tx_shift_reg;
  wire [7:0] stat_word = {stat_parity, stat_sel};
  wire [7:0] read_word = !addr_valid_reg ? SSP_INVALID_DATA :
                         addr_is_ctrl ? ctrl_rd_data :
                         addr_is_stat ? stat_word :
                         SSP_UNMAPPED_DATA;

  // reload on the byte-ending falling edge, else shift msb first
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_shift_reg <= SSP_INVALID_DATA;
    end else if (load_tx) begin
      tx_shift_reg <= read_word;
    end else if (sclk_fall) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
    end
  end

  // pin released while deselected; pull-up holds the line
  assign serial_data_out = tx_shift_reg[7];
  assign serial_data_oe = selected;

  // ---------------------------------------------------------------
  // fault pin
  // ---------------------------------------------------------------
  logic fault_reg;

  // refreshed only while deselected, like the status flags
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_reg <= 1'b0;
    end else if (cs_high) begin
      fault_reg <= |(stat_flat & SSP_FAULT_MASK);
    end
  end

  assign fault_n_out = 1'b0;
  assign fault_n_oe = fault_reg;

  // ---------------------------------------------------------------
  // sleep and drive control
  // ---------------------------------------------------------------
  logic step_reg;
  logic dir_reg;

  wire sleep = mode_word[SSP_SLEEP_BIT];
  wire moten = mode_word[SSP_MOTEN_BIT];

  // motion inputs are frozen in sleep; registers keep their value
  always_ff @(posedge clk) begin
    if (reset) begin
      step_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else if (!sleep) begin
      step_reg <= step_sync_reg[1];
      dir_reg <= dir_sync_reg[1];
    end
  end

  // clock gating request: run awake, or while the bus is active
  assign step_pulse_out = step_reg;
  assign dir_out = dir_reg;
  assign drivers_enable = moten & ~sleep;
  assign analog_enable = ~sleep;
  assign sleep_active = sleep;
  assign core_clock_run = ~sleep | selected;

endmodule : ssp_slave

`default_nettype wire

// ===== sim/ssp_slave_properties.sv
// pin-level assertions for the spi slave with sleep handling
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_properties
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic [SSP_NUM_STAT*SSP_STAT_BITS-1:0] status_event,
  input wire logic fault_n_out,
  input wire logic fault_n_oe,
  input wire logic step_pulse_out,
  input wire logic drivers_enable,
  input wire logic analog_enable,
  input wire logic sleep_active,
  input wire logic core_clock_run
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // pins must outlast the two-flop synchroniser before they count
  sequence s_desel; spi_cs_n [*4]; endsequence
  sequence s_sel; !spi_cs_n [*4]; endsequence
  // falling spi clock a few cycles back, high phase well before it
  sequence s_sclk_fell; $past(spi_clk, 6) && !$past(spi_clk, 2); endsequence
  a_oe_released: assert property (s_desel |-> !serial_data_oe)
    else $error("miso driven while deselected");
  a_oe_driven: assert property (s_sel |-> serial_data_oe)
    else $error("miso idle while selected");
  a_miso_shift: assert property ($changed(serial_data_out) && $past(serial_data_oe)
    && serial_data_oe |-> s_sclk_fell) else $error("miso moved off the falling edge");
  a_sleep_off: assert property (sleep_active |-> !drivers_enable && !analog_enable)
    else $error("drivers or analog on in sleep");
  a_wake_on: assert property (!sleep_active |-> analog_enable)
    else $error("analog off while awake");
  a_clock_gate: assert property (core_clock_run == (!sleep_active || serial_data_oe))
    else $error("core clock gating wrong");
  a_step_frozen: assert property (sleep_active && $past(sleep_active, 2) |-> $stable(step_pulse_out))
    else $error("step moved in sleep");
  a_fault_level: assert property (!fault_n_out)
    else $error("fault pin drives high");
  a_fault_set: assert property ((spi_cs_n && (|status_event)) [*4] |-> ##[0:4] fault_n_oe)
    else $error("fault not raised");
  a_fault_held: assert property (serial_data_oe [*4] |-> $stable(fault_n_oe))
    else $error("fault changed while selected");
  a_no_start: assert property ($rose(serial_data_oe) |-> !$past(spi_cs_n, 2))
    else $error("miso enabled without chip select");
endmodule : ssp_slave_properties
bind ssp_slave ssp_slave_properties chk (
  .clk(clk), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .status_event(status_event),
  .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe), .step_pulse_out(step_pulse_out),
  .drivers_enable(drivers_enable), .analog_enable(analog_enable), .sleep_active(sleep_active),
  .core_clock_run(core_clock_run)
);
`default_nettype wire

// ===== sim/ssp_spi_master.sv
// spi master model standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_master (
  input wire logic clk,
  input wire logic miso_line,
  output logic spi_clk,
  output logic spi_cs_n,
  output logic mosi
);
  // ----
  // link timing: 16 clk per half period, 160 ns spi period
  // ----
  logic [7:0] rx_byte;
  event rx_done;
  // bus parked at start: deselected, clock low, data high
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    mosi = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk
  // idle data line shows the inverse of its last bit
  task automatic frame(input logic sel);
    wait_clk(16);
    spi_cs_n = !sel;
    mosi = !mosi;
    wait_clk(16);
  endtask : frame
  // msb first, sample on rising, clock parks low
  task automatic shift(input logic [7:0] tx, input int n);
    // no clear here: the scoreboard may still read the last byte in this time step
    for (int i = 0; i < n; i++) begin
      mosi = tx[7 - i % 8];
      wait_clk(16);
      spi_clk = 1'b1;
      rx_byte = {rx_byte[6:0], miso_line};
      wait_clk(16);
      spi_clk = 1'b0;
    end
    -> rx_done;
  endtask : shift
endmodule : ssp_spi_master
`default_nettype wire

// ===== sim/ssp_slave_bench.sv
// self-checking bench for the spi slave with sleep handling
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_bench
  import ssp_pkg::*;
;
  // ----
  // signals and instances
  // ----
  logic clk, reset, spi_clk, spi_cs_n, serial_data_in;
  logic step_pulse_input, dir_input;
  logic [SSP_NUM_STAT*SSP_STAT_BITS-1:0] status_event;
  logic serial_data_out, serial_data_oe, fault_n_out, fault_n_oe, step_pulse_out, dir_out;
  logic drivers_enable, analog_enable, sleep_active, core_clock_run;
  // pull-up holds the data line high when released
  wire logic miso_line = serial_data_oe ? serial_data_out : 1'b1;
  integer seed = 32'hDFE9;
  int num_errors = 0;
  int tests_run = 0;
  logic [8:0] exp_q[$];
  logic [8:0] note;
  logic [7:0] d;
  logic [6:0] v;
  logic held;
  logic [7:0] ctrl_val [3];
  // start values; motion pins start at random levels
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    step_pulse_input = 1'($random(seed));
    dir_input = 1'($random(seed));
    status_event = 28'h0000000;
  end
  always #2.5 clk = !clk;
  ssp_spi_master m (.clk(clk), .miso_line(miso_line), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .mosi(serial_data_in));
  ssp_slave uut (.clk(clk), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .step_pulse_input(step_pulse_input), .dir_input(dir_input), .status_event(status_event),
    .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe), .step_pulse_out(step_pulse_out), .dir_out(dir_out),
    .drivers_enable(drivers_enable), .analog_enable(analog_enable), .sleep_active(sleep_active),
    .core_clock_run(core_clock_run));
  // ----
  // tasks
  // ----
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  // note the expected reply, then clock the byte; unknown replies are skipped
  task automatic xb(input logic [7:0] tx, input logic known, input logic [7:0] want, input int n = 8);
    exp_q.push_back({known, want});
    m.shift(tx, n);
  endtask : xb
  task automatic wr(input logic [4:0] idx, input logic [7:0] dat, input logic [7:0] old);
    m.frame(1'b1);
    xb({SSP_CMD_WRITE, idx}, 1'b0, 8'h00);
    xb(dat, 1'b1, old);
    m.frame(1'b0);
  endtask : wr
  task automatic rd(input logic [4:0] idx, input logic ko, input logic [7:0] old, input logic [7:0] want);
    m.frame(1'b1);
    xb({SSP_CMD_READ, idx}, ko, old);
    xb({SSP_CMD_READ, idx}, 1'b1, want);
    m.frame(1'b0);
  endtask : rd
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // scoreboard: each returned byte against the oldest note
  always @(m.rx_done) begin
    note = exp_q.pop_front();
    if (note[8]) check("miso", m.rx_byte, note[7:0]);
  end
  // hang guard
  initial begin
    m.wait_clk(90000);
    num_errors++;
    print_verdict();
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    rd(5'h00, 1'b1, SSP_INVALID_DATA, SSP_CTRL_RESET);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      wr(5'(i), d, SSP_CTRL_RESET);
      rd(5'(i), 1'b1, SSP_CTRL_RESET, d);
      ctrl_val[i] = d;
    end
    // unknown command keeps the index; unmapped index reads zero
    m.frame(1'b1);
    xb(8'h02, 1'b1, ctrl_val[2]);
    xb(8'hE1, 1'b1, ctrl_val[2]);
    xb(8'h1F, 1'b1, ctrl_val[2]);
    xb(8'h00, 1'b1, SSP_UNMAPPED_DATA);
    m.frame(1'b0);
    // fifteen and seventeen bit writes are dropped whole
    for (int k = 0; k < 2; k++) begin
      m.frame(1'b1);
      xb(8'h81, 1'b0, 8'h00);
      xb(~ctrl_val[1], 1'b0, 8'h00, 7 + 2 * k);
      m.frame(1'b0);
      rd(5'h01, 1'b0, 8'h00, ctrl_val[1]);
    end
    wr(5'h04, 8'h7F, 8'h00);
    rd(5'h04, 1'b1, 8'h00, 8'h00);
    wr(5'h03, 8'h80, 8'h00);
    check("awake", 8'({sleep_active, drivers_enable}), 8'h01);
    wr(5'h03, 8'hC0, 8'h80);
    check("sleep", 8'({sleep_active, analog_enable, drivers_enable, core_clock_run}), 8'h08);
    held = step_pulse_out;
    d = 8'(dir_out);
    step_pulse_input = !step_pulse_input;
    dir_input = !dir_out;
    m.wait_clk(8);
    check("frozen", 8'({step_pulse_out, dir_out}), 8'({held, d[0]}));
    rd(5'h00, 1'b1, 8'h80, ctrl_val[0]);
    wr(5'h03, 8'h80, 8'hC0);
    m.wait_clk(64);
    check("wake", 8'({step_pulse_out, dir_out, drivers_enable}), 8'({step_pulse_input, dir_input, 1'b1}));
    // each status group: latch, parity, fault, clear after read
    for (int g = 0; g < 4; g++) begin
      v = 7'($random(seed)) | 7'h01;
      status_event[g * 7 +: 7] = v;
      m.wait_clk(8);
      status_event = 28'h0000000;
      m.wait_clk(8);
      check("fault", 8'(fault_n_oe), 8'h01);
      rd(5'(4 + g), 1'b0, 8'h00, {^v, v});
      check("parity", 8'(^m.rx_byte), 8'h00);
      m.wait_clk(8);
      check("fault", 8'(fault_n_oe), 8'h00);
      rd(5'(4 + g), 1'b1, {^v, v}, 8'h00);
    end
    print_verdict();
  end
endmodule : ssp_slave_bench
`default_nettype wire
